// File: bdc_pkg.sv
// Shared constants and types of the backlight dimming controller
package bdc_pkg;
	// Register offsets
	localparam logic [7:0] REG_DIM  = 8'ha0;
	localparam logic [7:0] REG_SINK = 8'ha1;
	localparam logic [7:0] REG_UV   = 8'ha2;
	localparam logic [7:0] REG_RATE = 8'ha3;
	localparam logic [7:0] REG_EDGE = 8'ha4;
	localparam logic [7:0] REG_OC   = 8'ha5;
	localparam logic [7:0] REG_CTRL = 8'hff;
	// Values after reset (factory defaults)
	localparam logic [7:0] RST_DIM  = 8'h01;
	localparam logic [7:0] RST_SINK = 8'h05;
	localparam logic [7:0] RST_UV   = 8'h03;
	localparam logic [7:0] RST_RATE = 8'h01;
	localparam logic [7:0] RST_EDGE = 8'h00;
	localparam logic [7:0] RST_OC   = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	// Writable bits; the rest are reserved and read zero
	localparam logic [7:0] MSK_DIM  = 8'h03;
	localparam logic [7:0] MSK_SINK = 8'h0f;
	localparam logic [7:0] MSK_UV   = 8'h07;
	localparam logic [7:0] MSK_RATE = 8'h03;
	localparam logic [7:0] MSK_EDGE = 8'h03;
	localparam logic [7:0] MSK_OC   = 8'h01;
	localparam logic [7:0] MSK_CTRL = 8'h81;
	// Field positions
	localparam int STORE_BIT = 7;
	localparam int RSEL_BIT  = 0;
	// Serial address, 7 bits (write byte 58h)
	localparam logic [6:0] DEV_ADDR = 7'h2c;
	// Timing
	localparam int CLK_NS      = 100;
	localparam int OC_SHUT_NS  = 2000000;
	localparam int OC_SHUT_CYC = (OC_SHUT_NS + CLK_NS - 1) / CLK_NS;
	localparam int STORE_CYC   = 16;
	// Brightness levels on the 10-bit scale
	localparam logic [9:0] LVL_QUARTER = 10'h100;
	localparam logic [9:0] LVL_MIN     = 10'h00a;
	localparam logic [9:0] LVL_FULL    = 10'h3ff;
	// Dimming method encodings
	typedef enum logic [1:0] {DIM_PWM = 2'b00, DIM_MIXED = 2'b01, DIM_ANALOG = 2'b10} bdc_dim_t;
	// Serial slave states
	typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_REG, ST_WDAT, ST_RDAT} bdc_ser_t;
endpackage

// File: bdc_backlight_ctrl.sv
// Backlight dimming controller: duty decoder, sink drive, faults, serial config map
// Summary of operation
// - Sink with no current: disable, drop feedback
// - All sinks open: shut device down
// - Open sink stays off until enable toggles
// - Overcurrent: switch off until next period
// - Overcurrent over 2 ms latches shutdown
// - Policy bit clear suppresses latched shutdown
// - Overtemperature stops device, restarts when cleared
// - Method field: 00 PWM, 01 mixed, 10 analog
// - Mixed: duty becomes 10-bit brightness value
// - Mixed above quarter: continuous, amplitude 25-100%
// - Mixed below quarter: chop at quarter amplitude
// - Analog: continuous level from 1% to 100%
// - Direct PWM: active sinks follow input
// - Config map A0h-A5h, control at FFh
// - Factory defaults 01,05,03,01,00,00,00
// - Reserved bits ignore writes, read zero
// - Low nibble sets common full-scale current
// - Store bit copies to nonvolatile, self-clears
// - Read select bit picks working or nonvolatile
// - Register address increments per data byte
`timescale 1ns/1ns
`default_nettype none
module bdc_backlight_ctrl #(
	parameter int CNT_W   = 16,
	parameter int OC_CYC  = bdc_pkg::OC_SHUT_CYC
) (
	input  wire logic       CLK,
	input  wire logic       SYS_RST,
	input  wire logic       CHIP_ENABLE_IN,
	input  wire logic       BRIGHTNESS_PWM_INPUT,
	input  wire logic [5:0] SINK_NO_CURRENT,
	input  wire logic       OVERCURRENT,
	input  wire logic       PERIOD_START,
	input  wire logic       OVERTEMP,
	input  wire logic       SCL_IN,
	input  wire logic       SDA_IN,
	output logic            SDA_OUT,
	output logic            SDA_OE,
	output logic [5:0]      SINK_ON,
	output logic [9:0]      SINK_LEVEL,
	output logic [5:0]      FEEDBACK_SEL,
	output logic [3:0]      FULL_SCALE,
	output logic            POWER_SWITCH_EN,
	output logic            DEVICE_ACTIVE,
	output logic [2:0]      UNDERVOLTAGE_THRESHOLD,
	output logic [1:0]      SWITCHING_RATE_SELECT,
	output logic [1:0]      EDGE_SPEED_SELECT
);
	localparam int STORE_WAIT = bdc_pkg::STORE_CYC + 1;

	// Register index of an offset, 7 means unmapped
	function automatic logic [2:0] reg_idx(input logic [7:0] a);
		case (a)
			bdc_pkg::REG_DIM:  reg_idx = 3'h0;
			bdc_pkg::REG_SINK: reg_idx = 3'h1;
			bdc_pkg::REG_UV:   reg_idx = 3'h2;
			bdc_pkg::REG_RATE: reg_idx = 3'h3;
			bdc_pkg::REG_EDGE: reg_idx = 3'h4;
			bdc_pkg::REG_OC:   reg_idx = 3'h5;
			bdc_pkg::REG_CTRL: reg_idx = 3'h6;
			default:           reg_idx = 3'h7;
		endcase
	endfunction

	// Writable mask of a register index
	function automatic logic [7:0] reg_msk(input logic [2:0] i);
		case (i)
			3'h0:    reg_msk = bdc_pkg::MSK_DIM;
			3'h1:    reg_msk = bdc_pkg::MSK_SINK;
			3'h2:    reg_msk = bdc_pkg::MSK_UV;
			3'h3:    reg_msk = bdc_pkg::MSK_RATE;
			3'h4:    reg_msk = bdc_pkg::MSK_EDGE;
			3'h5:    reg_msk = bdc_pkg::MSK_OC;
			3'h6:    reg_msk = bdc_pkg::MSK_CTRL;
			default: reg_msk = 8'h00;
		endcase
	endfunction

	// Two-flop synchronisers for every outside input except SYS_RST
	logic [11:0] sy1;
	logic [11:0] sy2;
	always_ff @(posedge CLK)
	begin
		sy1 <= {SINK_NO_CURRENT, CHIP_ENABLE_IN, BRIGHTNESS_PWM_INPUT, OVERCURRENT, PERIOD_START, OVERTEMP, SCL_IN};
		sy2 <= sy1;
	end
	logic [5:0] nc_s;
	logic       en_s, pwm_s, oc_s, per_s, ot_s, scl_s, sda_s, sda_1;
	assign {nc_s, en_s, pwm_s, oc_s, per_s, ot_s, scl_s} = sy2;
	always_ff @(posedge CLK)
	begin
		sda_1 <= SDA_IN;
		sda_s <= sda_1;
	end

	// Edge history
	logic en_p, pwm_p, scl_p, sda_p;
	always_ff @(posedge CLK)
	begin
		en_p  <= en_s;
		pwm_p <= pwm_s;
		scl_p <= scl_s;
		sda_p <= sda_s;
	end
	wire en_rise  = en_s & ~en_p;
	wire pwm_rise = pwm_s & ~pwm_p;
	wire scl_rise = scl_s & ~scl_p;
	wire scl_fall = ~scl_s & scl_p;
	wire i_start  = scl_s & sda_p & ~sda_s;
	wire i_stop   = scl_s & ~sda_p & sda_s;

	// Factory default of a register index
	function automatic logic [7:0] rst_of(input logic [2:0] i);
		case (i)
			3'h0:    rst_of = bdc_pkg::RST_DIM;
			3'h1:    rst_of = bdc_pkg::RST_SINK;
			3'h2:    rst_of = bdc_pkg::RST_UV;
			3'h3:    rst_of = bdc_pkg::RST_RATE;
			3'h4:    rst_of = bdc_pkg::RST_EDGE;
			3'h5:    rst_of = bdc_pkg::RST_OC;
			default: rst_of = bdc_pkg::RST_CTRL;
		endcase
	endfunction

	// Working and nonvolatile configuration copies
	logic [7:0] cfg [0:6];
	logic [7:0] nvm [0:6];

	// Serial slave state
	bdc_pkg::bdc_ser_t st;
	logic [3:0] bit_cnt;
	logic [7:0] sh;
	logic [7:0] txd;
	logic [7:0] ptr;
	logic       ack;
	wire  [2:0] w_idx   = reg_idx(ptr);
	wire        byte_end = scl_fall & (bit_cnt == 4'h7);
	wire        ack_end  = scl_fall & (bit_cnt == 4'h8);
	wire        wr_acc   = byte_end & (st == bdc_pkg::ST_WDAT);
	wire        rsel    = cfg[6][bdc_pkg::RSEL_BIT];
	wire  [7:0] rd_byte = (w_idx == 3'h7) ? 8'h00 : ((rsel ? nvm[w_idx] : cfg[w_idx]) & reg_msk(w_idx));

	always_ff @(posedge CLK)
	begin
		if (SYS_RST | i_stop)
		begin
			st      <= bdc_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
			ack     <= 1'b0;
		end
		else if (i_start)
		begin
			st      <= bdc_pkg::ST_DEV;
			bit_cnt <= 4'hf;
			ack     <= 1'b0;
		end
		else if (st != bdc_pkg::ST_IDLE)
		begin
			if (scl_rise & (bit_cnt < 4'h8))
				sh <= {sh[6:0], sda_s};
			if (scl_rise & (bit_cnt == 4'h8) & (st == bdc_pkg::ST_RDAT) & sda_s)
				st <= bdc_pkg::ST_IDLE;
			if (scl_fall & (bit_cnt < 4'h7))
			begin
				bit_cnt <= bit_cnt + 4'h1;
				txd     <= {txd[6:0], 1'b0};
			end
			// Fall that closes the start condition is not a bit
			if (scl_fall & (bit_cnt == 4'hf))
				bit_cnt <= 4'h0;
			if (byte_end)
			begin
				bit_cnt <= 4'h8;
				case (st)
					bdc_pkg::ST_DEV:  ack <= (sh[7:1] == bdc_pkg::DEV_ADDR);
					bdc_pkg::ST_REG:  ack <= 1'b1;
					bdc_pkg::ST_WDAT: ack <= 1'b1;
					default:          ack <= 1'b0;
				endcase
				if (st == bdc_pkg::ST_DEV && sh[7:1] != bdc_pkg::DEV_ADDR)
					st <= bdc_pkg::ST_IDLE;
			end
			if (ack_end)
			begin
				bit_cnt <= 4'h0;
				ack     <= 1'b0;
				case (st)
					bdc_pkg::ST_DEV:  st <= sh[0] ? bdc_pkg::ST_RDAT : bdc_pkg::ST_REG;
					bdc_pkg::ST_REG:  st <= bdc_pkg::ST_WDAT;
					default:          st <= st;
				endcase
				if (st == bdc_pkg::ST_RDAT || (st == bdc_pkg::ST_DEV && sh[0]))
					txd <= rd_byte;
			end
		end
	end

	// pointer loads, then steps per data byte
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			ptr <= 8'h00;
		else if (byte_end & (st == bdc_pkg::ST_REG))
			ptr <= sh;
		else if (wr_acc | (byte_end & (st == bdc_pkg::ST_RDAT)))
			ptr <= ptr + 8'h01;
	end
	assign SDA_OUT = 1'b0;
	assign SDA_OE  = ack | ((st == bdc_pkg::ST_RDAT) & (bit_cnt < 4'h8) & ~txd[7]);

	// Nonvolatile store sequencer
	logic [4:0] store_cnt;
	wire        store_bit  = cfg[6][bdc_pkg::STORE_BIT];
	wire        store_done = store_bit & (store_cnt == 5'(bdc_pkg::STORE_CYC));
	wire        store_set  = wr_acc & (w_idx == 3'h6) & sh[bdc_pkg::STORE_BIT];
	// copy all registers and clear request in the same cycle
	always_ff @(posedge CLK)
	begin
		if (SYS_RST | ~store_bit)
			store_cnt <= 5'h00;
		else if (~store_done)
			store_cnt <= store_cnt + 5'h01;
	end
	always_ff @(posedge CLK)
	begin
		for (int i = 0; i < 7; i++)
		begin
			if (SYS_RST)
				nvm[i] <= rst_of(3'(i));
			else if (store_done)
				nvm[i] <= (i == 6) ? (cfg[i] & ~8'h80) : cfg[i];
		end
	end

	// working map, masked writes, reload on enable
	always_ff @(posedge CLK)
	begin
		for (int i = 0; i < 7; i++)
		begin
			if (SYS_RST)
				cfg[i] <= rst_of(3'(i));
			else if (en_rise)
				cfg[i] <= nvm[i];
			else if (wr_acc & (w_idx == 3'(i)))
				cfg[i] <= sh & reg_msk(3'(i));
			else if ((i == 6) & store_done & ~store_set)
				cfg[i] <= cfg[i] & ~8'h80;
		end
	end
	// common full-scale code and analog settings
	assign FULL_SCALE             = cfg[1][3:0];
	assign UNDERVOLTAGE_THRESHOLD = cfg[2][2:0];
	assign SWITCHING_RATE_SELECT  = cfg[3][1:0];
	assign EDGE_SPEED_SELECT      = cfg[4][1:0];

	logic [CNT_W-1:0] cnt_per, cnt_hi, per_meas, hi_meas;
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			cnt_per  <= '0;
			cnt_hi   <= '0;
			per_meas <= CNT_W'(1);
			hi_meas  <= '0;
		end
		else if (pwm_rise)
		begin
			per_meas <= (&cnt_per) ? cnt_per : cnt_per + CNT_W'(1); // Saturate, never zero
			hi_meas  <= cnt_hi;
			cnt_per  <= '0;
			cnt_hi   <= CNT_W'(1);
		end
		else
		begin
			if (~&cnt_per)
				cnt_per <= cnt_per + CNT_W'(1);
			if (pwm_s & ~&cnt_hi)
				cnt_hi <= cnt_hi + CNT_W'(1);
		end
	end
	// duty scaled to 10 bits, clamped to full
	wire [CNT_W+9:0] duty_q = {hi_meas, 10'h000} / {10'h000, per_meas};
	wire [9:0]       duty10 = (duty_q > (CNT_W+10)'(bdc_pkg::LVL_FULL)) ? bdc_pkg::LVL_FULL : duty_q[9:0];
	// chop window is four times the measured high time
	wire             chop_on = {2'b00, cnt_per} < {hi_meas, 2'b00};

	// Fault handling
	logic [5:0]  open_lat;
	logic        oc_lat, oc_cut;
	logic [15:0] oc_cnt;
	wire         overcurrent_policy_reg   = cfg[5][0];
	wire         active = en_s & ~ot_s & ~oc_lat & ~&open_lat;
	// open sink latches until enable drops
	always_ff @(posedge CLK)
	begin
		if (SYS_RST | ~en_s)
			open_lat <= 6'h00;
		else
			open_lat <= open_lat | (SINK_ON & nc_s);
	end
	// cut switch until next period, set wins
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			oc_cut <= 1'b0;
		else if (oc_s)
			oc_cut <= 1'b1;
		else if (per_s)
			oc_cut <= 1'b0;
	end
	always_ff @(posedge CLK)
	begin
		if (SYS_RST | ~oc_s)
			oc_cnt <= 16'h0000;
		else if (oc_cnt != 16'(OC_CYC))
			oc_cnt <= oc_cnt + 16'h0001;
	end
	always_ff @(posedge CLK)
	begin
		if (SYS_RST | ~en_s)
			oc_lat <= 1'b0;
		else if (oc_s & overcurrent_policy_reg & (oc_cnt == 16'(OC_CYC)))
			oc_lat <= 1'b1;
	end

	logic       next_on;
	logic [9:0] next_lvl;
	always_comb
	begin
		next_on  = 1'b0;
		next_lvl = bdc_pkg::LVL_FULL;
		case (bdc_pkg::bdc_dim_t'(cfg[0][1:0]))
			bdc_pkg::DIM_PWM: next_on = pwm_s;
			bdc_pkg::DIM_MIXED:
			begin
				next_on  = (duty10 >= bdc_pkg::LVL_QUARTER) | chop_on;
				next_lvl = (duty10 >= bdc_pkg::LVL_QUARTER) ? duty10 : bdc_pkg::LVL_QUARTER;
			end
			// continuous level, floored at one percent
			bdc_pkg::DIM_ANALOG:
			begin
				next_on  = 1'b1;
				next_lvl = (duty10 < bdc_pkg::LVL_MIN) ? bdc_pkg::LVL_MIN : duty10;
			end
			default: next_on = 1'b0;
		endcase
	end
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			SINK_ON         <= 6'h00;
			SINK_LEVEL      <= 10'h000;
			FEEDBACK_SEL    <= 6'h00;
			POWER_SWITCH_EN <= 1'b0;
			DEVICE_ACTIVE   <= 1'b0;
		end
		else
		begin
			SINK_ON         <= (active & next_on) ? ~(open_lat | (SINK_ON & nc_s)) : 6'h00;
			SINK_LEVEL      <= active ? next_lvl : 10'h000;
			FEEDBACK_SEL    <= active ? ~(open_lat | (SINK_ON & nc_s)) : 6'h00;
			POWER_SWITCH_EN <= active & ~oc_cut & ~oc_s;
			DEVICE_ACTIVE   <= active;
		end
	end

	a_open_sink_off: assert property (@(posedge CLK) disable iff (SYS_RST) (open_lat & SINK_ON) == 6'h00)
		else $error("open sink still driven");
	a_all_open_down: assert property (@(posedge CLK) disable iff (SYS_RST) (&open_lat) |=> !DEVICE_ACTIVE)
		else $error("device active with all sinks open");
	a_open_sticky: assert property (@(posedge CLK) disable iff (SYS_RST) en_s |=> (open_lat & $past(open_lat)) == $past(open_lat))
		else $error("open latch released while enabled");
	a_oc_switch_off: assert property (@(posedge CLK) disable iff (SYS_RST) oc_s |=> !POWER_SWITCH_EN ##1 (!POWER_SWITCH_EN || $past(per_s)))
		else $error("switch on during overcurrent period");
	a_oc_latch_set: assert property (@(posedge CLK) disable iff (SYS_RST) (oc_s && overcurrent_policy_reg && en_s && oc_cnt == 16'(OC_CYC)) |=> ##1 !DEVICE_ACTIVE)
		else $error("sustained overcurrent did not shut down");
	a_oc_policy_gate: assert property (@(posedge CLK) disable iff (SYS_RST) $rose(oc_lat) |-> $past(overcurrent_policy_reg))
		else $error("latched shutdown with policy cleared");
	a_thermal_off: assert property (@(posedge CLK) disable iff (SYS_RST) ot_s |=> !DEVICE_ACTIVE && SINK_ON == 6'h00)
		else $error("active during overtemperature");
	a_direct_follow: assert property (@(posedge CLK) disable iff (SYS_RST)
		(cfg[0][1:0] == 2'b00 && active && !(|nc_s)) |=> SINK_ON == ($past(pwm_s) ? ~$past(open_lat) : 6'h00))
		else $error("direct mode sinks not following input");
	a_mixed_floor: assert property (@(posedge CLK) disable iff (SYS_RST) (cfg[0][1:0] == 2'b01 && active) |=> SINK_LEVEL >= bdc_pkg::LVL_QUARTER)
		else $error("mixed level below quarter");
	a_store_clear: assert property (@(posedge CLK) disable iff (SYS_RST) $rose(store_bit) && !en_rise |-> ##[1:STORE_WAIT] !store_bit)
		else $error("store request never cleared");
	a_auto_inc: assert property (@(posedge CLK) disable iff (SYS_RST) wr_acc |=> ptr == $past(ptr) + 8'h01)
		else $error("pointer did not advance after write");
endmodule // bdc_backlight_ctrl
`default_nettype wire

// File: bdc_host_model.sv
// Host model: serial configuration master and brightness PWM source
`timescale 1ns/1ns
`default_nettype none
module bdc_host_model (
	input  wire logic clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv,
	output logic      pwm
);
	int hi_cyc   = 0;
	int nack_cnt = 0;
	// PWM source, 400-cycle period, high for hi_cyc
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
		pwm = 1'b0;
		forever
			for (int i = 0; i < 400; i++)
			begin
				@(negedge clk);
				pwm = (i < hi_cyc);
			end
	end
	// Half bit time, 4 clock cycles
	task automatic half;
		repeat (4) @(negedge clk);
	endtask
	task automatic start;
		sda_drv = 1'b1;
		half;
		scl = 1'b1;
		half;
		sda_drv = 1'b0;
		half;
		scl = 1'b0;
	endtask
	task automatic stop;
		sda_drv = 1'b0;
		half;
		scl = 1'b1;
		half;
		sda_drv = 1'b1;
		half;
	endtask
	// One byte MSB first plus the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic nk, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
		begin
			sda_drv = d[i];
			half;
			scl = 1'b1;
			half;
			r[i] = sda_line;
			scl = 1'b0;
		end
		sda_drv = nk;
		half;
		scl = 1'b1;
		half;
		if (nk && sda_line !== 1'b0)
			nack_cnt++;
		scl = 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
		logic [7:0] r;
		start;
		xfer({bdc_pkg::DEV_ADDR, 1'b0}, 1'b1, r);
		xfer(a, 1'b1, r);
		foreach (d[i])
			xfer(d[i], 1'b1, r);
		stop;
	endtask
	// Pointer set, repeated start, one byte read with master nack
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		logic [7:0] r;
		start;
		xfer({bdc_pkg::DEV_ADDR, 1'b0}, 1'b1, r);
		xfer(a, 1'b1, r);
		start;
		xfer({bdc_pkg::DEV_ADDR, 1'b1}, 1'b1, r);
		sda_drv = 1'b1;
		xfer(8'hff, 1'b1, v);
		nack_cnt--;
		stop;
	endtask
endmodule // bdc_host_model
`default_nettype wire

// File: backlight_dimming_control_bench.sv
// Self-checking bench of the backlight dimming controller
`timescale 1ns/1ns
`default_nettype none
module backlight_dimming_control_bench;
	localparam int OC = 50;
	logic       clk, sys_rst, en, oc, pstart, otemp, scl, sda_drv, pwm, sda_oe;
	logic [5:0] nocur, sink_on, fb_sel;
	logic [9:0] level;
	logic [3:0] fscale;
	logic [2:0] uvth;
	logic [1:0] rate_sel, edge_spd;
	logic       psw, active;
	logic [7:0] v;
	int         fail_count = 0;
	int         tests_run  = 0;
	wire        sda_line = sda_drv & ~sda_oe;
	bdc_host_model i_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv), .pwm(pwm));
	bdc_backlight_ctrl #(.OC_CYC(OC)) i_dut (
		.CLK(clk), .SYS_RST(sys_rst), .CHIP_ENABLE_IN(en), .BRIGHTNESS_PWM_INPUT(pwm),
		.SINK_NO_CURRENT(nocur), .OVERCURRENT(oc), .PERIOD_START(pstart), .OVERTEMP(otemp),
		.SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(), .SDA_OE(sda_oe), .SINK_ON(sink_on),
		.SINK_LEVEL(level), .FEEDBACK_SEL(fb_sel), .FULL_SCALE(fscale), .POWER_SWITCH_EN(psw),
		.DEVICE_ACTIVE(active), .UNDERVOLTAGE_THRESHOLD(uvth), .SWITCHING_RATE_SELECT(rate_sel),
		.EDGE_SPEED_SELECT(edge_spd)
	);
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Align to a PWM rise, then move on by n cycles
	task automatic after_rise(input int n);
		@(posedge pwm);
		cyc(n);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic t_defaults;
		logic [7:0] a[8] = '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'hff, 8'ha6};
		logic [7:0] e[8] = '{8'h01, 8'h05, 8'h03, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
		foreach (a[i])
		begin
			i_host.rd(a[i], v);
			check(v, e[i]);
		end
		check(fscale, 4'h5);
		check({uvth, rate_sel, edge_spd}, 7'h34);
	endtask
	task automatic t_reserved;
		logic [7:0] e[6] = '{8'h03, 8'h0f, 8'h07, 8'h03, 8'h03, 8'h01};
		i_host.wr(8'ha0, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
		check({uvth, rate_sel, edge_spd}, 7'h7f);
		foreach (e[i])
		begin
			i_host.rd(8'ha0 + 8'(i), v);
			check(v, e[i]);
		end
		check(fscale, 4'hf);
		i_host.wr(8'ha0, '{8'h00, 8'h05, 8'h03, 8'h01, 8'h00, 8'h00});
	endtask
	task automatic t_modes;
		i_host.hi_cyc = 100;
		cyc(1200);
		after_rise(50);
		check(sink_on, 6'h3f);
		cyc(150);
		check(sink_on, 6'h00);
		i_host.wr(8'ha0, '{8'h02});
		i_host.hi_cyc = 200;
		cyc(1200);
		check(16'(level > 10'd480 && level < 10'd540), 16'h1);
		i_host.wr(8'ha0, '{8'h01});
		cyc(1200);
		after_rise(300);
		check(sink_on, 6'h3f);
		check(16'(level > 10'd480 && level < 10'd540), 16'h1);
		i_host.hi_cyc = 40;
		cyc(1200);
		after_rise(20);
		check(level, bdc_pkg::LVL_QUARTER);
		check(sink_on, 6'h3f);
		cyc(280);
		check(sink_on, 6'h00);
		i_host.hi_cyc = 200;
		cyc(1200);
		i_host.wr(8'ha0, '{8'h03});
		check(sink_on, 6'h00);
		i_host.wr(8'ha0, '{8'h01});
		cyc(20);
	endtask
	task automatic t_open;
		nocur = 6'h01;
		cyc(10);
		nocur = 6'h00;
		cyc(10);
		check({sink_on[0], fb_sel[0], sink_on[1]}, 3'b001);
		nocur = 6'h3f;
		cyc(10);
		nocur = 6'h00;
		cyc(10);
		check(active, 1'b0);
		en = 1'b0;
		cyc(10);
		en = 1'b1;
		cyc(1200);
		check(sink_on, 6'h3f);
	endtask
	task automatic oc_run(input int n);
		oc = 1'b1;
		cyc(n);
		oc = 1'b0;
		cyc(5);
		pstart = 1'b1;
		cyc(1);
		pstart = 1'b0;
		cyc(6);
	endtask
	task automatic t_oc;
		oc = 1'b1;
		cyc(6);
		check(psw, 1'b0);
		oc = 1'b0;
		cyc(10);
		check(psw, 1'b0);
		oc_run(1);
		check(psw, 1'b1);
		oc_run(OC + 20);
		check({active, psw}, 2'b11);
		i_host.wr(8'ha5, '{8'h01});
		oc_run(OC - 10);
		check(active, 1'b1);
		oc_run(OC + 20);
		check(active, 1'b0);
		en = 1'b0;
		cyc(10);
		en = 1'b1;
		cyc(20);
		check(active, 1'b1);
	endtask
	task automatic t_temp;
		otemp = 1'b1;
		cyc(6);
		check(active, 1'b0);
		otemp = 1'b0;
		cyc(10);
		check(active, 1'b1);
	endtask
	task automatic t_store;
		i_host.wr(8'ha0, '{8'h02});
		i_host.wr(8'hff, '{8'h80});
		cyc(30);
		i_host.rd(8'hff, v);
		check(v, 8'h00);
		i_host.wr(8'ha0, '{8'h00});
		i_host.wr(8'hff, '{8'h01});
		i_host.rd(8'ha0, v);
		check(v, 8'h02);
		i_host.wr(8'hff, '{8'h00});
		i_host.rd(8'ha0, v);
		check(v, 8'h00);
	endtask
	// Watchdog, well beyond the expected run
	initial
	begin
		#9000000;
		fail_count++;
		wrap_up;
	end
	initial
	begin
		sys_rst = 1'b1;
		en = 1'b1;
		oc = 1'b0;
		pstart = 1'b0;
		otemp = 1'b0;
		nocur = 6'h00;
		cyc(12);
		sys_rst = 1'b0;
		cyc(5);
		t_defaults;
		t_reserved;
		t_modes;
		t_open;
		t_oc;
		t_temp;
		t_store;
		check(16'(i_host.nack_cnt), 16'h0);
		wrap_up;
	end
endmodule // backlight_dimming_control_bench
`default_nettype wire
